// ---- design/nfh_params.svh ----
// Constants for the flash host-port controller.
// Assumes a 200 MHz mclk and an external parallel NOR flash on the pins.
// What this block does
// - Host sends reset after error or identification (left to the caller, sent only on an NFH_OP_RESET_CMD request)
// - Write: write enable, chip select low, OE high
// - Unlock bypass programs in two cycles
// - Protect and unprotect cycle address encoding
// - Protect all groups before unprotect (left to the caller, not checked here)
// - Accelerated programs use two-cycle sequence
`ifndef NFH_PARAMS_SVH
`define NFH_PARAMS_SVH
`define NFH_CLK_MHZ 200
`define NFH_ACCESS_NS 90
`define NFH_ACCESS_CYC ((`NFH_ACCESS_NS * `NFH_CLK_MHZ + 999) / 1000)
`define NFH_OE_NS 35
`define NFH_OE_CYC ((`NFH_OE_NS * `NFH_CLK_MHZ + 999) / 1000)
`define NFH_WPULSE_NS 35
`define NFH_WPULSE_CYC ((`NFH_WPULSE_NS * `NFH_CLK_MHZ + 999) / 1000)
`define NFH_SETUP_CYC 1
`define NFH_HOLD_CYC 1
`define NFH_RESET_NS 500
`define NFH_RESET_CYC ((`NFH_RESET_NS * `NFH_CLK_MHZ + 999) / 1000)
`define NFH_UNLOCK1_ADDR 22'h00_0555
`define NFH_UNLOCK2_ADDR 22'h00_02AA
`define NFH_UNLOCK1_DATA 16'h00AA
`define NFH_UNLOCK2_DATA 16'h0055
`define NFH_CMD_PROGRAM 16'h00A0
`define NFH_CMD_AUTOSEL 16'h0090
`define NFH_CMD_BYPASS 16'h0020
`define NFH_CMD_RESET 16'h00F0
`define NFH_CMD_BYP_EXIT1 16'h0090
`define NFH_CMD_BYP_EXIT2 16'h0000
`define NFH_ID_MAKER_ADDR 22'h00_0100
`define NFH_ID_PART_ADDR 22'h00_0001
`define NFH_ID_VERIFY_LOW 22'h00_0002
`define NFH_PROT_LOW 22'h00_0002
`define NFH_UNPROT_LOW 22'h00_0042
`define NFH_SECT_LSB 15
`endif

// ---- design/nfh_pkg.sv ----
// Types shared by the flash host-port controller files.
// Assumes nothing beyond the constants header.
package nfh_pkg;
   typedef enum logic [3:0] {
      NFH_OP_READ,
      NFH_OP_CMD_WRITE,
      NFH_OP_PROGRAM,
      NFH_OP_BYP_PROGRAM,
      NFH_OP_BYP_ENTER,
      NFH_OP_BYP_EXIT,
      NFH_OP_ID_ENTER,
      NFH_OP_ID_READ,
      NFH_OP_RESET_CMD,
      NFH_OP_PROTECT,
      NFH_OP_UNPROTECT,
      NFH_OP_HW_RESET
   } nfh_op_type;
   typedef enum logic [1:0] {
      NFH_ID_MAKER,
      NFH_ID_PART,
      NFH_ID_VERIFY
   } nfh_id_type;
endpackage

// ---- design/nfh_cyc_if.sv ----
// Single bus-cycle request carrier between sequencer and cycle engine.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
interface nfh_cyc_if;
   logic req;
   logic wr;
   logic [21:0] addr;
   logic [15:0] wdata;
   logic done;
   logic [15:0] rdata;
   modport seq (output req, output wr, output addr, output wdata,
      input done, input rdata);
   modport eng (input req, input wr, input addr, input wdata,
      output done, output rdata);
endinterface

// ---- design/nfh_cycle_engine.sv ----
// One flash bus cycle at a time: read or write strobe timing.
// Assumes the sequencer holds the request until done pulses.
`timescale 1ns/1ps
`include "nfh_params.svh"
module nfh_cycle_engine #(
   parameter int ACC_CYC = `NFH_ACCESS_CYC,
   parameter int WP_CYC = `NFH_WPULSE_CYC
) (
   input wire logic mclk,
   input wire logic rst_b,
   nfh_cyc_if.eng cyc,
   input wire logic [15:0] dataIn,
   output logic chipSel_b,
   output logic outEn_b,
   output logic wrEn_b,
   output logic [21:0] addrOut,
   output logic [15:0] dataOut,
   output logic dataOe
);
   typedef enum logic [1:0] {ENG_IDLE, ENG_SETUP, ENG_STROBE, ENG_HOLD}
      nfh_eng_type;
   nfh_eng_type st_r, st_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic cs_r, cs_nxt, oe_r, oe_nxt, we_r, we_nxt, drv_r, drv_nxt;
   logic done_r, done_nxt;
   logic [21:0] a_r, a_nxt;
   logic [15:0] d_r, d_nxt, rd_r, rd_nxt;

   // Counts live in an 8-bit down counter
   if (ACC_CYC < 1 || ACC_CYC > 255 || WP_CYC < 1 || WP_CYC > 255) begin
      $error("cycle counts out of range");
   end

   ////////////////////////////////////////////////////////////////////
   // Strobe sequencing; address is set a cycle before the strobe falls
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      cs_nxt = cs_r;
      oe_nxt = oe_r;
      we_nxt = we_r;
      drv_nxt = drv_r;
      a_nxt = a_r;
      d_nxt = d_r;
      rd_nxt = rd_r;
      done_nxt = 1'b0;
      unique case (st_r)
         ENG_IDLE: begin
            cs_nxt = 1'b1; // Chip deselected between cycles
            oe_nxt = 1'b1;
            we_nxt = 1'b1;
            drv_nxt = 1'b0;
            if (cyc.req && !done_r) begin
               a_nxt = cyc.addr;
               d_nxt = cyc.wdata;
               drv_nxt = cyc.wr;
               cs_nxt = 1'b0;
               st_nxt = ENG_SETUP;
            end
         end
         ENG_SETUP: begin
            // Write holds OE high so the cycle is never a read
            oe_nxt = cyc.wr;
            we_nxt = !cyc.wr;
            cnt_nxt = cyc.wr ? 8'(WP_CYC) : 8'(ACC_CYC);
            st_nxt = ENG_STROBE;
         end
         ENG_STROBE: begin
            if (cnt_r <= 8'h01) begin
               // WE rises with data still driven
               rd_nxt = dataIn;
               we_nxt = 1'b1;
               oe_nxt = 1'b1; // Device floats its outputs
               st_nxt = ENG_HOLD;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         ENG_HOLD: begin
            cs_nxt = 1'b1;
            drv_nxt = 1'b0;
            done_nxt = 1'b1;
            st_nxt = ENG_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= ENG_IDLE;
         cnt_r <= 8'h00;
         cs_r <= 1'b1;
         oe_r <= 1'b1;
         we_r <= 1'b1;
         drv_r <= 1'b0;
         a_r <= 22'h00_0000;
         d_r <= 16'h0000;
         rd_r <= 16'h0000;
         done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         cs_r <= cs_nxt;
         oe_r <= oe_nxt;
         we_r <= we_nxt;
         drv_r <= drv_nxt;
         a_r <= a_nxt;
         d_r <= d_nxt;
         rd_r <= rd_nxt;
         done_r <= done_nxt;
      end
   end

   assign chipSel_b = cs_r;
   assign outEn_b = oe_r;
   assign wrEn_b = we_r;
   assign addrOut = a_r;
   assign dataOut = d_r;
   assign dataOe = drv_r;
   assign cyc.done = done_r;
   assign cyc.rdata = rd_r;
endmodule

// ---- design/nfh_host.sv ----
// Host controller for a parallel NOR flash: turns operation requests into
// command sequences on the flash pins. Assumes strobes synchronous to mclk;
// elevated voltages on reset and write-protect pins come from board
// switches driven by the level outputs of this block.
`timescale 1ns/1ps
`include "nfh_params.svh"
module nfh_host
   import nfh_pkg::*;
#(
   parameter int RESET_CYC = `NFH_RESET_CYC
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic opValid,
   input nfh_pkg::nfh_op_type opCode,
   input wire logic [21:0] opAddr,
   input wire logic [15:0] opData,
   input wire logic accelReq,
   input wire logic wrProtReq,
   output logic opReady,
   output logic opDone,
   output logic [15:0] opRdata,
   output logic bypassActive,
   output logic idActive,
   output logic chipSel_b,
   output logic outEn_b,
   output logic wrEn_b,
   output logic [21:0] address_bus,
   output logic [15:0] dataBusOut,
   output logic dataBusOe,
   input wire logic [15:0] dataBusIn,
   output logic hwReset_b,
   output logic resetElevated,
   output logic wrProtHigh,
   output logic accelHighVolt
);
   import nfh_pkg::*;

   typedef enum logic [2:0] {HS_IDLE, HS_ISSUE, HS_WAIT, HS_RST, HS_FIN}
      nfh_hs_type;

   nfh_cyc_if cyc();

   nfh_hs_type st_r, st_nxt;
   nfh_op_type op_r, op_nxt;
   logic [2:0] idx_r, idx_nxt, last_r, last_nxt;
   logic [21:0] a_r, a_nxt;
   logic [15:0] d_r, d_nxt, rdat_r, rdat_nxt;
   logic [15:0] rcnt_r, rcnt_nxt;
   logic byp_r, byp_nxt, id_r, id_nxt, done_r, done_nxt;
   logic hrst_r, hrst_nxt, elev_r, elev_nxt;
   logic wp_r, wp_nxt, acc_r, acc_nxt;
   logic rdy_r, rdy_nxt;

   // Pulse length lives in a 16-bit down counter
   if (RESET_CYC < 1 || RESET_CYC > 65535) begin
      $error("RESET_CYC out of range");
   end

   ////////////////////////////////////////////////////////////////////
   // Step table: number of bus cycles each operation needs
   function automatic logic [2:0] stepCount(nfh_op_type op, logic byp);
      unique case (op)
         NFH_OP_READ, NFH_OP_ID_READ, NFH_OP_RESET_CMD,
         NFH_OP_CMD_WRITE: stepCount = 3'd1;
         NFH_OP_PROTECT, NFH_OP_UNPROTECT: stepCount = 3'd1;
         NFH_OP_PROGRAM: stepCount = 3'd4;
         NFH_OP_BYP_PROGRAM, NFH_OP_BYP_EXIT: stepCount = 3'd2;
         NFH_OP_BYP_ENTER, NFH_OP_ID_ENTER: stepCount = 3'd3;
         default: stepCount = 3'd1;
      endcase
      if (op == NFH_OP_PROGRAM && byp)
         stepCount = 3'd2; // Bypass mode shortens program
   endfunction

   // Address, data and direction of step i of an operation
   function automatic logic [38:0] stepWord(nfh_op_type op, logic [2:0] i,
         logic [21:0] a, logic [15:0] d, logic byp);
      logic [21:0] sa;
      logic [15:0] sd;
      logic w;
      sa = a;
      sd = d;
      w = 1'b1;
      unique case (op)
         NFH_OP_READ, NFH_OP_ID_READ: w = 1'b0;
         NFH_OP_CMD_WRITE: w = 1'b1;
         NFH_OP_RESET_CMD: sd = `NFH_CMD_RESET;
         NFH_OP_PROTECT: begin
            // Group address on top bits, low pattern selects protect
            sa = {a[21:`NFH_SECT_LSB], 15'h0000} | `NFH_PROT_LOW;
            sd = 16'h0000;
         end
         NFH_OP_UNPROTECT: begin
            // Caller must protect every group first; not checked
            sa = {a[21:`NFH_SECT_LSB], 15'h0000} | `NFH_UNPROT_LOW;
            sd = 16'h0000;
         end
         NFH_OP_BYP_EXIT: begin
            sa = a;
            sd = (i == 3'd0) ? `NFH_CMD_BYP_EXIT1 : `NFH_CMD_BYP_EXIT2;
         end
         default: begin
            // Unlock preamble shared by command sequences
            if ((op == NFH_OP_PROGRAM && byp) ||
                  op == NFH_OP_BYP_PROGRAM) begin
               // Two-cycle program while in bypass
               sa = (i == 3'd0) ? `NFH_UNLOCK1_ADDR : a;
               sd = (i == 3'd0) ? `NFH_CMD_PROGRAM : d;
            end else if (i == 3'd0) begin
               sa = `NFH_UNLOCK1_ADDR;
               sd = `NFH_UNLOCK1_DATA;
            end else if (i == 3'd1) begin
               sa = `NFH_UNLOCK2_ADDR;
               sd = `NFH_UNLOCK2_DATA;
            end else if (i == 3'd2) begin
               sa = `NFH_UNLOCK1_ADDR;
               unique case (op)
                  NFH_OP_BYP_ENTER: sd = `NFH_CMD_BYPASS;
                  NFH_OP_ID_ENTER: sd = `NFH_CMD_AUTOSEL;
                  default: sd = `NFH_CMD_PROGRAM;
               endcase
            end
         end
      endcase
      stepWord = {w, sa, sd};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Operation sequencer
   always_comb begin
      st_nxt = st_r;
      op_nxt = op_r;
      idx_nxt = idx_r;
      last_nxt = last_r;
      a_nxt = a_r;
      d_nxt = d_r;
      rdat_nxt = rdat_r;
      rcnt_nxt = rcnt_r;
      byp_nxt = byp_r;
      id_nxt = id_r;
      done_nxt = 1'b0;
      hrst_nxt = hrst_r;
      elev_nxt = elev_r;
      // Pin level straps follow the user levels; accelerate also raises write protect
      wp_nxt = wrProtReq | accelReq;
      acc_nxt = accelReq;
      if (accelReq)
         byp_nxt = 1'b1; // Accelerate voltage forces bypass
      else if (acc_r)
         byp_nxt = 1'b0;
      unique case (st_r)
         HS_IDLE: begin
            if (opValid) begin
               op_nxt = opCode;
               a_nxt = opAddr;
               d_nxt = opData;
               idx_nxt = 3'd0;
               last_nxt = stepCount(opCode, byp_r) - 3'd1;
               if (opCode == NFH_OP_HW_RESET) begin
                  hrst_nxt = 1'b0; // Held low for the pulse time
                  rcnt_nxt = 16'(RESET_CYC);
                  st_nxt = HS_RST;
               end else begin
                  // Protect cycles need reset at elevated level
                  elev_nxt = (opCode == NFH_OP_PROTECT) ||
                     (opCode == NFH_OP_UNPROTECT);
                  st_nxt = HS_ISSUE;
               end
            end
         end
         HS_ISSUE: st_nxt = HS_WAIT;
         HS_WAIT: begin
            if (cyc.done) begin
               rdat_nxt = cyc.rdata;
               if (idx_r == last_r)
                  st_nxt = HS_FIN;
               else begin
                  idx_nxt = idx_r + 3'd1;
                  st_nxt = HS_ISSUE;
               end
            end
         end
         HS_RST: begin
            if (rcnt_r <= 16'h0001) begin
               hrst_nxt = 1'b1;
               // Device back in array read, modes dropped; bypass kept while accelerate is requested
               byp_nxt = accelReq;
               id_nxt = 1'b0;
               st_nxt = HS_FIN;
            end else
               rcnt_nxt = rcnt_r - 16'h0001;
         end
         HS_FIN: begin
            done_nxt = 1'b1;
            elev_nxt = 1'b0;
            unique case (op_r)
               NFH_OP_BYP_ENTER: byp_nxt = 1'b1;
               NFH_OP_BYP_EXIT: byp_nxt = accelReq;
               NFH_OP_ID_ENTER: id_nxt = 1'b1;
               NFH_OP_RESET_CMD: id_nxt = 1'b0; // Leaves identification
               default: ;
            endcase
            st_nxt = HS_IDLE;
         end
         default: st_nxt = HS_IDLE;
      endcase
      // Ready comes from a flop, not from a state decode
      rdy_nxt = (st_nxt == HS_IDLE);
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= HS_IDLE;
         op_r <= NFH_OP_READ;
         idx_r <= 3'd0;
         last_r <= 3'd0;
         a_r <= 22'h00_0000;
         d_r <= 16'h0000;
         rdat_r <= 16'h0000;
         rcnt_r <= 16'h0000;
         byp_r <= 1'b0;
         id_r <= 1'b0;
         done_r <= 1'b0;
         hrst_r <= 1'b1;
         elev_r <= 1'b0;
         wp_r <= 1'b0;
         acc_r <= 1'b0;
         rdy_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         idx_r <= idx_nxt;
         last_r <= last_nxt;
         a_r <= a_nxt;
         d_r <= d_nxt;
         rdat_r <= rdat_nxt;
         rcnt_r <= rcnt_nxt;
         byp_r <= byp_nxt;
         id_r <= id_nxt;
         done_r <= done_nxt;
         hrst_r <= hrst_nxt;
         elev_r <= elev_nxt;
         wp_r <= wp_nxt;
         acc_r <= acc_nxt;
         rdy_r <= rdy_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Request to the cycle engine, held through HS_WAIT until done
   logic [38:0] word;
   always_comb begin
      word = stepWord(op_r, idx_r, a_r, d_r, byp_r);
   end
   assign cyc.req = (st_r == HS_WAIT);
   assign cyc.wr = word[38];
   assign cyc.addr = word[37:16];
   assign cyc.wdata = word[15:0];

   nfh_cycle_engine u_eng (
      .mclk(mclk),
      .rst_b(rst_b),
      .cyc(cyc),
      .dataIn(dataBusIn),
      .chipSel_b(chipSel_b),
      .outEn_b(outEn_b),
      .wrEn_b(wrEn_b),
      .addrOut(address_bus),
      .dataOut(dataBusOut),
      .dataOe(dataBusOe)
   );

   assign opReady = rdy_r;
   assign opDone = done_r;
   assign opRdata = rdat_r;
   assign bypassActive = byp_r;
   assign idActive = id_r;
   assign hwReset_b = hrst_r;
   assign resetElevated = elev_r;
   assign wrProtHigh = wp_r;
   assign accelHighVolt = acc_r;
endmodule

// ---- sim/nfh_host_checker.sv ----
// Pin and handshake checks for the flash host controller.
// Assumes one mclk domain; bound onto every nfh_host instance.
`timescale 1ns/1ps
module nfh_host_checker #(
   parameter int RESET_CYC = 100
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic opValid,
   input wire logic opReady,
   input wire logic opDone,
   input wire logic chipSel_b,
   input wire logic outEn_b,
   input wire logic wrEn_b,
   input wire logic [21:0] address_bus,
   input wire logic [15:0] dataBusOut,
   input wire logic dataBusOe,
   input wire logic hwReset_b,
   input wire logic resetElevated,
   input wire logic wrProtHigh,
   input wire logic accelHighVolt
);
   logic [15:0] lowCnt_r;
   logic [15:0] lowCnt_nxt;
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////
   // Length of the current flash reset pulse, cleared when it ends
   always_comb begin
      lowCnt_nxt = hwReset_b ? 16'h0000 : lowCnt_r + 16'h0001;
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lowCnt_r <= 16'h0000;
      end else begin
         lowCnt_r <= lowCnt_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // A write strobe only inside chip select and with outputs off
   AST_WR_STROBES:
      assert property (!wrEn_b |-> !chipSel_b && outEn_b)
      else $error("write strobe outside a write cycle");
   // Host drives the data bus only while the flash outputs are off
   AST_DRIVE_OE:
      assert property (dataBusOe |-> outEn_b)
      else $error("bus contention with flash outputs");
   AST_PROT_CODE:
      assert property (!wrEn_b && resetElevated |-> address_bus[1:0] == 2'b10)
      else $error("protect cycle with wrong low address bits");
   AST_ACCEL_WP:
      assert property (accelHighVolt |-> wrProtHigh)
      else $error("accelerate voltage with write protect low");
   AST_WR_HOLD:
      assert property (!wrEn_b ##1 !wrEn_b |->
         $stable(address_bus) && $stable(dataBusOut))
      else $error("address or data moved inside a write pulse");
   AST_WR_PULSE:
      assert property ($fell(wrEn_b) |-> !wrEn_b [*7])
      else $error("write pulse too short");
   AST_RD_ADDR:
      assert property (!outEn_b ##1 !outEn_b |-> $stable(address_bus))
      else $error("address moved during a read strobe");
   AST_RST_WIDTH:
      assert property ($rose(hwReset_b) |-> lowCnt_r >= RESET_CYC)
      else $error("flash reset pulse too short");
   AST_RST_QUIET:
      assert property (!hwReset_b |-> chipSel_b && !dataBusOe)
      else $error("bus activity during flash reset");
   AST_DONE_PULSE:
      assert property (opDone |=> !opDone)
      else $error("done longer than one cycle");
   AST_DONE_BOUND:
      assert property (opValid && opReady |-> ##[2:600] opDone)
      else $error("operation never completed");
   // Main scenarios reached
   COV_PROT: cover property (!wrEn_b && resetElevated);
   COV_ACCEL: cover property (!wrEn_b && accelHighVolt);
   COV_HWRST: cover property ($rose(hwReset_b));
endmodule
bind nfh_host nfh_host_checker #(.RESET_CYC(RESET_CYC)) hostChk (
   .mclk(mclk), .rst_b(rst_b), .opValid(opValid), .opReady(opReady),
   .opDone(opDone), .chipSel_b(chipSel_b), .outEn_b(outEn_b),
   .wrEn_b(wrEn_b), .address_bus(address_bus), .dataBusOut(dataBusOut),
   .dataBusOe(dataBusOe), .hwReset_b(hwReset_b),
   .resetElevated(resetElevated), .wrProtHigh(wrProtHigh),
   .accelHighVolt(accelHighVolt));

// ---- sim/nfh_flash_model.sv ----
// Behavioural parallel NOR flash: commands, identification, protection.
// Assumes the host resolves the shared data bus; no clock of its own.
`timescale 1ns/1ps
module nfh_flash_model #(
   parameter int ACC_NS = 10,
   parameter logic [15:0] MAKER_CODE = 16'h0A5C, // arbitrary value
   parameter logic [15:0] PART_CODE = 16'h1357, // arbitrary value
   parameter logic [15:0] CFG_CODE = 16'h0C3F // arbitrary value
) (
   input wire logic chipSel_b,
   input wire logic outEn_b,
   input wire logic wrEn_b,
   input wire logic [21:0] address_bus,
   input wire logic [15:0] dqIn,
   output wire logic [15:0] dqOut,
   input wire logic hwReset_b,
   input wire logic resetElevated,
   input wire logic wrProtHigh,
   input wire logic accelHighVolt
);
   logic [15:0] mem [int];
   logic [31:0] prot = 32'h0000_0000;
   logic [21:0] latA = 22'h00_0000;
   logic [15:0] lastQ = 16'h0000;
   int step = 0;
   logic idMode = 1'b0;
   logic byp = 1'b0;
   logic pgm = 1'b0;
   logic exitArm = 1'b0;
   // Outputs on only when selected, enabled and out of reset
   wire devOe = !chipSel_b && !outEn_b && hwReset_b;
   ////////////////////////////////////////////////////////////////////////
   // Read data: erased array reads all ones
   function automatic logic [15:0] rd(input logic [21:0] a);
      if (!idMode) return mem.exists(a) ? mem[a] : 16'hFFFF;
      if (a[6]) return 16'h0000;
      case (a[1:0])
         2'b00: return a[8] ? MAKER_CODE : CFG_CODE;
         2'b01: return PART_CODE;
         2'b10: return {15'h0000, prot[a[21:17]]};
         default: return 16'h0000;
      endcase
   endfunction
   // Boundary sector is the first one
   function automatic logic canWrite(input logic [21:0] a);
      if (accelHighVolt) return 1'b1;
      if (a[21:15] == 7'h00 && !wrProtHigh) return 1'b0;
      if (resetElevated) return 1'b1;
      return !prot[a[21:17]];
   endfunction
   // One accepted write cycle through the command state
   task automatic wrCycle(input logic [21:0] a, input logic [15:0] d);
      if (resetElevated && a[1:0] == 2'b10) begin
         prot[a[21:17]] = !a[6];
      end else if (pgm) begin
         pgm = 1'b0;
         if (canWrite(a)) mem[a] = d;
      end else if (d == 16'h00F0) begin
         step = 0;
         idMode = 1'b0;
      end else if (byp || accelHighVolt) begin
         if (d == 16'h00A0) pgm = 1'b1;
         else if (d == 16'h0090) exitArm = 1'b1;
         else if (exitArm && d == 16'h0000) byp = 1'b0;
      end else if (step == 0 && a[11:0] == 12'h555 && d == 16'h00AA) begin
         step = 1;
      end else if (step == 1 && a[11:0] == 12'h2AA && d == 16'h0055) begin
         step = 2;
      end else if (step == 2 && a[11:0] == 12'h555) begin
         step = 0;
         pgm = (d == 16'h00A0);
         idMode = idMode || (d == 16'h0090);
         byp = (d == 16'h0020);
         exitArm = 1'b0;
      end else begin
         step = 0;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Address on the falling write edge, data on the rising one
   always @(negedge wrEn_b) latA = address_bus;
   always @(posedge wrEn_b) begin
      if (!chipSel_b && outEn_b && hwReset_b) wrCycle(latA, dqIn);
   end
   // Reset pin aborts every command state except exitArm
   always @(negedge hwReset_b) begin
      step = 0;
      idMode = 1'b0;
      byp = 1'b0;
      pgm = 1'b0;
   end
   // Released bus shows the inverse of the last word, never a held value
   always @(address_bus, devOe) if (devOe) lastQ = rd(address_bus);
   assign #(ACC_NS) dqOut = devOe ? rd(address_bus) : ~lastQ;
endmodule

// ---- sim/nfh_host_tb.sv ----
// Self-checking bench for nfh_host with a behavioural flash on its pins.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
module nfh_host_tb;
   import nfh_pkg::*;
   localparam logic [15:0] MAKER = 16'h0A5C; // arbitrary value
   localparam logic [15:0] PART = 16'h1357; // arbitrary value
   localparam logic [15:0] CFG = 16'h0C3F; // arbitrary value
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic opValid = 1'b0;
   nfh_op_type opCode = NFH_OP_READ;
   logic [21:0] opAddr = 22'h00_0000;
   logic [15:0] opData = 16'h0000;
   logic accelReq = 1'b0;
   logic wrProtReq = 1'b1;
   logic opReady, opDone, bypassActive, idActive, chipSel_b, outEn_b;
   logic wrEn_b, dataBusOe, hwReset_b, resetElevated, wrProtHigh;
   logic accelHighVolt;
   logic [15:0] opRdata, dataBusOut, dataBusIn, flashQ;
   logic [21:0] address_bus;
   int err_count = 0;
   int num_checks = 0;
   assign dataBusIn = dataBusOe ? dataBusOut : flashQ;
   always #2.5 mclk = ~mclk;
   nfh_host #(.RESET_CYC(8)) uut (.mclk(mclk), .rst_b(rst_b),
      .opValid(opValid), .opCode(opCode), .opAddr(opAddr), .opData(opData),
      .accelReq(accelReq), .wrProtReq(wrProtReq), .opReady(opReady),
      .opDone(opDone), .opRdata(opRdata), .bypassActive(bypassActive),
      .idActive(idActive), .chipSel_b(chipSel_b), .outEn_b(outEn_b),
      .wrEn_b(wrEn_b), .address_bus(address_bus), .dataBusOut(dataBusOut),
      .dataBusOe(dataBusOe), .dataBusIn(dataBusIn), .hwReset_b(hwReset_b),
      .resetElevated(resetElevated), .wrProtHigh(wrProtHigh),
      .accelHighVolt(accelHighVolt));
   // Slow flash: data settles late in the read strobe
   nfh_flash_model #(.ACC_NS(60), .MAKER_CODE(MAKER), .PART_CODE(PART),
      .CFG_CODE(CFG)) flash (.chipSel_b(chipSel_b), .outEn_b(outEn_b),
      .wrEn_b(wrEn_b), .address_bus(address_bus), .dqIn(dataBusIn),
      .dqOut(flashQ), .hwReset_b(hwReset_b), .resetElevated(resetElevated),
      .wrProtHigh(wrProtHigh), .accelHighVolt(accelHighVolt));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One operation; entered and left just after a clock edge
   task automatic do_op(input nfh_op_type c,
      input logic [21:0] a = 22'h00_0000, input logic [15:0] d = 16'h0000);
      int n;
      n = 0;
      opCode = c;
      opAddr = a;
      opData = d;
      opValid = 1'b1;
      while (opReady !== 1'b1 && n < 1000) begin
         @(posedge mclk);
         #1 n++;
      end
      @(posedge mclk);
      #1 opValid = 1'b0;
      while (opDone !== 1'b1 && n < 2000) begin
         @(posedge mclk);
         #1 n++;
      end
      if (n >= 2000) begin
         err_count++;
         close_out;
      end
   endtask
   task automatic rd_chk(input logic [21:0] a, input logic [15:0] exp);
      do_op(NFH_OP_READ, a);
      chk(opRdata, exp);
   endtask
   task automatic id_chk(input logic [21:0] a, input logic [15:0] exp);
      do_op(NFH_OP_ID_READ, a);
      chk(opRdata, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_boot_prog;
      chk({chipSel_b, dataBusOe, 14'h0000}, 16'h8000);
      rd_chk(22'h00_1234, 16'hFFFF);
      do_op(NFH_OP_PROGRAM, 22'h08_0010, 16'h5A3C);
      rd_chk(22'h08_0010, 16'h5A3C);
   endtask
   task automatic t_bypass;
      do_op(NFH_OP_BYP_ENTER);
      chk({15'h0000, bypassActive}, 16'h0001);
      do_op(NFH_OP_BYP_PROGRAM, 22'h08_0020, 16'h0F0F);
      do_op(NFH_OP_BYP_EXIT);
      chk({15'h0000, bypassActive}, 16'h0000);
      rd_chk(22'h08_0020, 16'h0F0F);
   endtask
   task automatic t_ident;
      do_op(NFH_OP_ID_ENTER);
      chk({15'h0000, idActive}, 16'h0001);
      id_chk(22'h00_0100, MAKER);
      id_chk(22'h00_0000, CFG);
      id_chk(22'h00_0001, PART);
      id_chk(22'h08_0002, 16'h0000);
      do_op(NFH_OP_RESET_CMD);
      rd_chk(22'h08_0010, 16'h5A3C);
   endtask
   task automatic t_wrprot;
      wrProtReq = 1'b0;
      do_op(NFH_OP_PROGRAM, 22'h00_0004, 16'h1111);
      rd_chk(22'h00_0004, 16'hFFFF);
      wrProtReq = 1'b1;
      do_op(NFH_OP_PROGRAM, 22'h00_0004, 16'h2222);
      rd_chk(22'h00_0004, 16'h2222);
   endtask
   // Every group protected before the single unprotect, as required
   task automatic t_protect;
      for (int g = 0; g < 32; g++) begin
         do_op(NFH_OP_PROTECT, {g[4:0], 17'h0_0000});
      end
      do_op(NFH_OP_ID_ENTER);
      id_chk(22'h08_0002, 16'h0001);
      do_op(NFH_OP_RESET_CMD);
      do_op(NFH_OP_PROGRAM, 22'h09_8000, 16'h3C3C);
      rd_chk(22'h09_8000, 16'hFFFF);
      do_op(NFH_OP_UNPROTECT, 22'h08_0000);
      do_op(NFH_OP_PROGRAM, 22'h09_8000, 16'h3C3C);
      rd_chk(22'h09_8000, 16'h3C3C);
   endtask
   task automatic t_accel;
      accelReq = 1'b1;
      do_op(NFH_OP_BYP_PROGRAM, 22'h0A_0010, 16'h4321);
      chk({wrProtHigh, accelHighVolt, 14'h0000}, 16'hC000);
      accelReq = 1'b0;
      rd_chk(22'h0A_0010, 16'h4321);
      do_op(NFH_OP_PROGRAM, 22'h0A_0020, 16'h7777);
      rd_chk(22'h0A_0020, 16'hFFFF);
   endtask
   task automatic t_hwreset;
      do_op(NFH_OP_ID_ENTER);
      do_op(NFH_OP_HW_RESET);
      chk({15'h0000, idActive}, 16'h0000);
      rd_chk(22'h09_8000, 16'h3C3C);
   endtask
   task automatic close_out;
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence after five reset cycles
   initial begin
      repeat (5) @(posedge mclk);
      #1 rst_b = 1'b1;
      t_boot_prog;
      t_bypass;
      t_ident;
      t_wrprot;
      t_protect;
      t_accel;
      t_hwreset;
      close_out;
   end
   // Watchdog well beyond the roughly 1500 cycles the run needs
   initial begin
      #(30000 * 5);
      err_count++;
      close_out;
   end
endmodule
